// file: core/ats_translated_path.sv
// Attribute and permission path for upstream root-complex traffic
module ats_translated_path
  import ats_path_pkg::*;
#(
  parameter int          NUM_STREAMS = 4,
  parameter logic        S2_EXEC_SPLIT = 1'b1,
  parameter int          SW = (NUM_STREAMS > 1) ? $clog2(NUM_STREAMS) : 1
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Avalon-MM register slave
  input  wire logic [7:0]    address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  output logic      [31:0]   readdata,
  output logic               waitrequest,
  // Incoming transaction
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [1:0]    in_kind,
  input  wire logic [SW-1:0] in_stream,
  input  wire logic [63:0]   in_addr,
  input  wire logic          in_no_snoop,
  input  wire logic          in_instr,
  input  wire logic          in_priv,
  input  wire logic [2:0]    in_req_perm,
  // Table walker
  output logic               walk_valid,
  output logic               walk_stage2_only,
  output logic [63:0]        walk_addr,
  output logic               walk_instr,
  output logic               walk_priv,
  output logic               walk_write_intent,
  input  wire logic          walk_done,
  input  wire logic          walk_fault,
  input  wire logic [63:0]   walk_s1_addr,
  input  wire logic [63:0]   walk_out_addr,
  input  wire logic [3:0]    walk_s1_attr,
  input  wire logic [3:0]    walk_s2_attr,
  input  wire logic [2:0]    walk_s1_perm,
  input  wire logic [2:0]    walk_s2_perm,
  input  wire logic [5:0]    walk_s1_size,
  input  wire logic [5:0]    walk_s2_size,
  // Downstream transaction
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [63:0]        out_addr,
  output logic [3:0]         out_attr,
  output logic               out_instr,
  output logic               out_priv,
  // Translation completion
  output logic               cpl_valid,
  input  wire logic          cpl_ready,
  output logic [63:0]        cpl_addr,
  output logic [2:0]         cpl_perm,
  output logic [5:0]         cpl_size,
  output logic               cpl_nosnoop,
  // Fault event
  output logic               fault_pulse
);
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_LOOKUP = 5'b00010,
    ST_WALK   = 5'b00100,
    ST_EMIT   = 5'b01000,
    ST_CPL    = 5'b10000
  } state_t;

  state_t            st;
  logic [9:0]        tbl [NUM_STREAMS];
  logic [9:0]        ent;
  logic [15:0]       fault_cnt;
  logic [7:0]        st_off;
  logic [63:0]       k_addr, strip_addr, cpl_base;
  logic [5:0]        min_size;
  logic [3:0]        r_attr, fin_attr, res_attr, pre_attr;
  logic [2:0]        ctrl, k_perm, grant, cfg;
  logic [1:0]        k_kind, mode;
  logic              ack, k_ns, check, split, lk_fault, lk_bypass, walk_end;
  logic              go_emit, go_cpl, ns_eff, use_s2, wr_fire, in_stream_hit;

  ////////////////////////////////////////////////////////////////////////
  // Register slave

  // One wait cycle on every access; readdata is loaded in that cycle
  assign waitrequest = (read || write) && !ack;
  assign wr_fire     = write && ack;
  assign st_off      = address - REG_STREAM_BASE;
  assign in_stream_hit = address >= REG_STREAM_BASE && st_off[7:2] < 6'(NUM_STREAMS) && st_off[1:0] == 2'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  // Unmapped offsets read as zero and ignore writes
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h0;
    end else if (read && !ack) begin
      readdata <= 32'h0;
      if (address == REG_CTRL) begin
        readdata <= {29'h0, ctrl};
      end else if (address == REG_CAPS) begin
        readdata <= {15'h0, 16'(NUM_STREAMS), S2_EXEC_SPLIT};
      end else if (address == REG_FAULTS) begin
        readdata <= {11'h0, st, fault_cnt};
      end else if (in_stream_hit) begin
        readdata <= {22'h0, tbl[st_off[SW+1:2]]};
      end
    end
  end

  // Control bits steer check, attribute encoding and no-snoop support
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wr_fire && address == REG_CTRL) begin
      ctrl <= writedata[2:0];
    end
  end

  // Per-stream configuration entries
  for (genvar i = 0; i < NUM_STREAMS; i++) begin : g_tbl
    always_ff @(posedge clk) begin
      if (reset) begin
        tbl[i] <= ENT_RESET;
      end else if (wr_fire && address == 8'(REG_STREAM_BASE + 4 * i)) begin
        tbl[i] <= writedata[9:0];
      end
    end
  end

  // Fault counter; a fault in the clearing cycle still counts
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_cnt <= 16'h0;
    end else if (fault_pulse) begin
      fault_cnt <= (wr_fire && address == REG_FAULTS) ? 16'h1 : fault_cnt + 16'h1;
    end else if (wr_fire && address == REG_FAULTS) begin
      fault_cnt <= 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decisions

  assign check  = ctrl[CTRL_CHECK];
  assign mode   = ent[ENT_MODE_LSB +: 2];
  assign cfg    = ent[ENT_CFG_LSB +: 3];
  assign split  = mode == ATS_SPLIT && check && cfg == CFG_NESTED;
  // Encoded attribute sits above the physical range; strip it before output
  assign strip_addr = {8'h0, k_addr[ADDR_ENC_LSB-1:0]};

  // With check on, mode 00 and non-nested mode 10 refuse translated traffic; with check off both bypass
  assign lk_fault  = st == ST_LOOKUP && k_kind == KIND_TRANS && check
                   && (mode == ATS_OFF || (mode == ATS_SPLIT && !split));
  assign lk_bypass = st == ST_LOOKUP && k_kind == KIND_TRANS && !lk_fault && !(check && mode == ATS_SPLIT);
  assign walk_end  = st == ST_WALK && walk_done;
  assign go_emit   = lk_bypass || (walk_end && !walk_fault && k_kind != KIND_TREQ);
  assign go_cpl    = (walk_end && k_kind == KIND_TREQ) || (st == ST_LOOKUP && k_kind == KIND_TREQ && mode == ATS_OFF);
  assign fault_pulse = lk_fault || (walk_end && walk_fault);

  // Untranslated input is the fixed cacheable shareable value, merged with stage 1 when config bit 0 is set
  always_comb begin
    pre_attr = r_attr;
    if (k_kind != KIND_TRANS) begin
      pre_attr = cfg[0] ? combine_attr(ATTR_FIXED_IN, walk_s1_attr) : ATTR_FIXED_IN;
    end
  end

  assign use_s2 = st == ST_WALK && (k_kind == KIND_TRANS || cfg[1]);
  assign ns_eff = k_ns && ctrl[CTRL_NOSNOOP] && k_kind != KIND_TREQ;

  attr_resolve u_resolve (
    .in_attr  (pre_attr),
    .s2_attr  (walk_s2_attr),
    .use_s2   (use_s2),
    .fwb      (ent[ENT_FWB]),
    .no_snoop (ns_eff),
    .fin_attr (fin_attr),
    .out_attr (res_attr)
  );

  // Completion contents
  assign cpl_base = split ? walk_s1_addr : walk_out_addr;
  assign grant    = walk_s1_perm & walk_s2_perm & k_perm;
  assign min_size = (walk_s1_size < walk_s2_size) ? walk_s1_size : walk_s2_size;
  assign cpl_nosnoop = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  assign in_ready = st == ST_IDLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= ST_IDLE;
    end else begin
      case (st)
        ST_IDLE:   st <= in_valid ? ST_LOOKUP : ST_IDLE;
        ST_LOOKUP: st <= lk_fault ? ST_IDLE : go_emit ? ST_EMIT : go_cpl ? ST_CPL : ST_WALK;
        ST_WALK:   st <= go_emit ? ST_EMIT : go_cpl ? ST_CPL : walk_end ? ST_IDLE : ST_WALK;
        ST_EMIT:   st <= out_ready ? ST_IDLE : ST_EMIT;
        ST_CPL:    st <= cpl_ready ? ST_IDLE : ST_CPL;
        default:   st <= ST_IDLE;
      endcase
    end
  end

  // Capture the request; no-snoop is folded into the output attribute, not carried as a sideband
  always_ff @(posedge clk) begin
    if (reset) begin
      k_kind <= KIND_UNTRANS;
      k_addr <= 64'h0;
      k_ns   <= 1'b0;
      k_perm <= 3'h0;
      ent    <= ENT_RESET;
    end else if (st == ST_IDLE && in_valid) begin
      k_kind <= in_kind;
      k_addr <= in_addr;
      k_ns   <= in_no_snoop;
      k_perm <= in_req_perm;
      ent    <= tbl[in_stream];
    end
  end

  // Translated source attribute: encoded in the address or the fixed value
  always_ff @(posedge clk) begin
    if (reset) begin
      r_attr <= ATTR_FIXED_IN;
    end else if (st == ST_IDLE) begin
      r_attr <= ctrl[CTRL_ATTR_ENC] ? in_addr[ADDR_ENC_LSB +: 4] : ATTR_FIXED_IN;
    end
  end

  // Overrides act before the stage-2 walk and its permission check
  always_ff @(posedge clk) begin
    if (reset) begin
      walk_instr <= 1'b0;
      walk_priv  <= 1'b0;
    end else if (st == ST_IDLE && in_valid) begin
      walk_instr <= tbl[in_stream][ENT_INSTR_LSB+1] ? tbl[in_stream][ENT_INSTR_LSB] : in_instr;
      walk_priv  <= (S2_EXEC_SPLIT && tbl[in_stream][ENT_PRIV_LSB+1])
                    ? tbl[in_stream][ENT_PRIV_LSB] : in_priv;
    end
  end

  // Walker request; translated mode 10 walks stage 2 only
  always_ff @(posedge clk) begin
    if (reset) begin
      walk_valid        <= 1'b0;
      walk_stage2_only  <= 1'b0;
      walk_addr         <= 64'h0;
      walk_write_intent <= 1'b0;
    end else if (st == ST_LOOKUP && !lk_fault && !go_emit && !go_cpl) begin
      walk_valid        <= 1'b1;
      walk_stage2_only  <= k_kind == KIND_TRANS;
      walk_addr         <= (k_kind == KIND_TRANS) ? strip_addr : k_addr;
      walk_write_intent <= k_perm[1];
    end else if (walk_end) begin
      walk_valid <= 1'b0;
    end
  end

  // Downstream transaction with the final attribute
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_addr  <= 64'h0;
      out_attr  <= ATTR_FIXED_IN;
      out_instr <= 1'b0;
      out_priv  <= 1'b0;
    end else if (go_emit) begin
      out_valid <= 1'b1;
      out_addr  <= lk_bypass ? strip_addr : walk_out_addr;
      out_attr  <= res_attr;
      out_instr <= walk_instr;
      out_priv  <= walk_priv;
    end else if (st == ST_EMIT && out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // Completion; the attribute rides in the unused address bits when enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      cpl_valid <= 1'b0;
      cpl_addr  <= 64'h0;
      cpl_perm  <= 3'h0;
      cpl_size  <= 6'h0;
    end else if (go_cpl) begin
      cpl_valid <= 1'b1;
      cpl_addr  <= {4'h0, ctrl[CTRL_ATTR_ENC] ? fin_attr : 4'h0, cpl_base[ADDR_ENC_LSB-1:0]};
      cpl_perm  <= (st == ST_WALK && !walk_fault) ? grant : 3'h0;
      cpl_size  <= min_size;
    end else if (st == ST_CPL && cpl_ready) begin
      cpl_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  nosnoop_down_a: assert property (go_emit && ns_eff && fin_attr[3:2] != MT_DEVICE
    |=> out_attr == ATTR_NOSNOOP) else $error("no-snoop downgrade missing");
  device_keep_a: assert property (go_emit && fin_attr[3:2] == MT_DEVICE
    |=> out_attr == $past(fin_attr)) else $error("device attribute altered");
  cpl_n_a: assert property (cpl_valid |-> !cpl_nosnoop && cpl_addr[63:60] == 4'h0)
    else $error("completion N field set");
  split_addr_a: assert property (go_cpl && split && st == ST_WALK
    |=> cpl_addr[55:0] == $past(walk_s1_addr[55:0])) else $error("split completion address wrong");
  perm_limit_a: assert property (cpl_valid |-> (cpl_perm & ~k_perm) == 3'h0)
    else $error("permission not requested was granted");
  size_min_a: assert property (go_cpl |=> cpl_size <= $past(walk_s1_size) && cpl_size <= $past(walk_s2_size))
    else $error("translation size too large");
  bypass_addr_a: assert property (lk_bypass |=> out_valid && out_addr == $past(strip_addr))
    else $error("bypass address altered");
  s2_walk_a: assert property (st == ST_LOOKUP && k_kind == KIND_TRANS && split
    |=> walk_valid && walk_stage2_only) else $error("stage-2 walk not started");
  s2_addr_a: assert property (st == ST_LOOKUP && k_kind == KIND_TRANS && split
    |=> walk_addr == $past(strip_addr)) else $error("stage-2 walk address wrong");
  split_check_a: assert property (st == ST_LOOKUP && k_kind == KIND_TRANS && mode == ATS_SPLIT && !check
    |-> !lk_fault ##1 out_valid) else $error("mode 10 without check mishandled");
  cpl_no_ns_a: assert property (go_cpl |-> !ns_eff) else $error("no-snoop leaked into completion");
  bus_answer_a: assert property ($rose(read) |=> !waitrequest) else $error("bus answer late");

  split_cpl_c: cover property (go_cpl && split && !walk_fault);
  bypass_c: cover property (lk_bypass ##1 out_valid ##[1:4] !out_valid);
  downgrade_c: cover property (go_emit && ns_eff && fin_attr[3:2] == MT_WB);
endmodule

// file: core/attr_resolve.sv
// Stage-2 attribute merge followed by the no-snoop downgrade
module attr_resolve
  import ats_path_pkg::*;
(
  // Attribute sources
  input  wire logic [3:0] in_attr,
  input  wire logic [3:0] s2_attr,
  input  wire logic       use_s2,
  input  wire logic       fwb,
  input  wire logic       no_snoop,
  // Results
  output logic      [3:0] fin_attr,
  output logic      [3:0] out_attr
);
  logic [3:0] merged;

  // Plain stage-2 merge; forced writeback keeps only its shareability half
  assign merged = combine_attr(in_attr, s2_attr);

  // Forced writeback first, downgrade last, so the downgrade sees the true final type
  always_comb begin
    fin_attr = in_attr;
    if (use_s2) begin
      if (fwb) begin
        fin_attr = {s2_attr[3:2], merged[1:0]};
      end else begin
        fin_attr = merged;
      end
    end
    out_attr = fin_attr;
    if (no_snoop && fin_attr[3:2] != MT_DEVICE) begin
      out_attr = ATTR_NOSNOOP;
    end
  end
endmodule

// file: include/ats_path_pkg.sv
// Shared constants for the translated-transaction attribute path
package ats_path_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_CAPS        = 8'h04;
  localparam logic [7:0] REG_FAULTS      = 8'h08;
  localparam logic [7:0] REG_STREAM_BASE = 8'h10;
  // Control register bits
  localparam int CTRL_CHECK    = 0;
  localparam int CTRL_ATTR_ENC = 1;
  localparam int CTRL_NOSNOOP  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Stream entry fields: mode[1:0] config[4:2] fwb[5] instr_ov[7:6] priv_ov[9:8]
  localparam int ENT_MODE_LSB  = 0;
  localparam int ENT_CFG_LSB   = 2;
  localparam int ENT_FWB       = 5;
  localparam int ENT_INSTR_LSB = 6;
  localparam int ENT_PRIV_LSB  = 8;
  localparam logic [9:0] ENT_RESET = 10'h000;
  // ATS mode and stream configuration codes
  localparam logic [1:0] ATS_OFF   = 2'h0;
  localparam logic [1:0] ATS_FULL  = 2'h1;
  localparam logic [1:0] ATS_SPLIT = 2'h2;
  localparam logic [2:0] CFG_NESTED = 3'h7;
  // Attribute: type[3:2] shareability[1:0]
  localparam logic [1:0] MT_DEVICE = 2'h0;
  localparam logic [1:0] MT_NC     = 2'h1;
  localparam logic [1:0] MT_WB     = 2'h3;
  localparam logic [1:0] SH_OUTER  = 2'h2;
  localparam logic [1:0] SH_INNER  = 2'h3;
  localparam logic [3:0] ATTR_FIXED_IN = {MT_WB, SH_INNER};
  localparam logic [3:0] ATTR_NOSNOOP  = {MT_NC, SH_OUTER};
  // Attribute field in translated addresses, above the physical range
  localparam int ADDR_ENC_LSB = 56;
  // Transaction kinds
  localparam logic [1:0] KIND_UNTRANS = 2'h0;
  localparam logic [1:0] KIND_TRANS   = 2'h1;
  localparam logic [1:0] KIND_TREQ    = 2'h2;

  // Weaker memory type, stronger shareability
  function automatic logic [3:0] combine_attr(input logic [3:0] a, input logic [3:0] b);
    combine_attr[3:2] = (a[3:2] < b[3:2]) ? a[3:2] : b[3:2];
    combine_attr[1:0] = (a[1:0] > b[1:0]) ? a[1:0] : b[1:0];
  endfunction
endpackage

// file: verif/ats_translated_attr_path_test.sv
// Self-checking bench for the translated-transaction attribute path
module ats_translated_attr_path_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ats_path_pkg::*;
  typedef struct {logic [63:0] addr; logic [3:0] attr; logic instr; logic priv;} out_exp_t;
  typedef struct {logic [63:0] addr; logic [2:0] perm; logic [5:0] size;} cpl_exp_t;
  localparam logic [63:0] PA_MASK = 64'h00ff_ffff_ffff_ffff;
  logic         clk, reset, read, write, waitrequest, in_valid, in_ready, in_no_snoop, in_instr, in_priv;
  logic         walk_valid, walk_done, out_valid, out_ready, out_instr, out_priv;
  logic         cpl_valid, cpl_ready, cpl_nosnoop, fault_pulse;
  logic [7:0]   address;
  logic [31:0]  writedata, readdata, seed;
  logic [1:0]   in_kind, in_stream;
  logic [63:0]  in_addr, out_addr, cpl_addr;
  logic [2:0]   in_req_perm, cpl_perm;
  logic [5:0]   cpl_size;
  logic [3:0]   out_attr;
  logic [154:0] rsp, wr;
  logic [3:0]   tab [3] = '{4'hf, 4'ha, 4'h0};
  int           n_mismatch, checks_done, n_fault, cyc;
  out_exp_t     oq[$];
  cpl_exp_t     cq[$];
  out_exp_t     oe;
  cpl_exp_t     ce;

  ats_translated_path dut (.clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .in_valid, .in_ready, .in_kind, .in_stream, .in_addr, .in_no_snoop, .in_instr, .in_priv, .in_req_perm,
    .walk_valid, .walk_stage2_only(), .walk_addr(), .walk_instr(), .walk_priv(), .walk_write_intent(),
    .walk_done, .walk_fault(wr[0]), .walk_s1_addr(wr[154:91]), .walk_out_addr(wr[90:27]),
    .walk_s1_attr(wr[26:23]), .walk_s2_attr(wr[22:19]), .walk_s1_perm(wr[18:16]), .walk_s2_perm(wr[15:13]),
    .walk_s1_size(wr[12:7]), .walk_s2_size(wr[6:1]), .out_valid, .out_ready, .out_addr, .out_attr,
    .out_instr, .out_priv, .cpl_valid, .cpl_ready, .cpl_addr, .cpl_perm, .cpl_size, .cpl_nosnoop, .fault_pulse);
  walk_model wm (.clk, .reset, .walk_valid, .rsp, .walk_done, .rsp_out(wr));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Weaker type, stronger shareability
  function automatic logic [3:0] mix(input logic [3:0] a, input logic [3:0] b);
    return {(a[3:2] < b[3:2]) ? a[3:2] : b[3:2], (a[1:0] > b[1:0]) ? a[1:0] : b[1:0]};
  endfunction
  // No-snoop pulls any cacheable type down; device types are left alone
  function automatic logic [3:0] nsd(input logic [3:0] a, input logic ns);
    return (ns && a[3:2] != MT_DEVICE) ? ATTR_NOSNOOP : a;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_up(input string what);
    n_mismatch++;
    $display("wrong value %s expected handshake seen timeout", what);
    test_done();
  endtask

  // Avalon access: request held until waitrequest is seen low at a rising edge
  task automatic reg_acc(input logic wen, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wen;
    write <= wen;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) give_up("waitrequest");
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] q;
    reg_acc(1'b0, a, 32'h0, q);
    chk("readdata", 64'(exp), 64'(q & mask));
  endtask

  // One transaction; waits for idle so the walk answer is not changed under a pending walk
  task automatic send(input logic [1:0] k, input logic [1:0] s, input logic [63:0] a, input logic ns,
                      input logic [2:0] p, input logic [154:0] r, input logic ins, input logic pv);
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (in_ready === 1'b1 && in_valid === 1'b0) break;
    end
    if (i == 50) give_up("in_ready");
    in_kind <= k;
    in_stream <= s;
    in_addr <= a;
    in_no_snoop <= ns;
    in_req_perm <= p;
    in_instr <= ins;
    in_priv <= pv;
    rsp <= r;
    in_valid <= 1'b1;
    @(posedge clk);
    if (in_ready !== 1'b1) give_up("accept");
    in_valid <= 1'b0;
  endtask

  // Result watcher: stalls both outputs and matches each result with the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    out_ready <= (cyc % 3) != 0;
    cpl_ready <= cyc[1];
    if (fault_pulse === 1'b1) n_fault++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (oq.size() == 0) give_up("out_valid");
      oe = oq.pop_front();
      chk("out_addr", oe.addr, out_addr);
      chk("out_attr", 64'(oe.attr), 64'(out_attr));
      chk("out_instr", 64'(oe.instr), 64'(out_instr));
      chk("out_priv", 64'(oe.priv), 64'(out_priv));
    end
    if (cpl_valid === 1'b1 && cpl_ready === 1'b1) begin
      if (cq.size() == 0) give_up("cpl_valid");
      ce = cq.pop_front();
      chk("cpl_addr", ce.addr, cpl_addr);
      chk("cpl_perm", 64'(ce.perm), 64'(cpl_perm));
      chk("cpl_size", 64'(ce.size), 64'(cpl_size));
      chk("cpl_nosnoop", 64'h0, 64'(cpl_nosnoop));
    end
  end

  initial begin
    logic [63:0]  a;
    logic [3:0]   e, t, m;
    logic [154:0] r;
    logic [31:0]  d;
    logic [2:0]   p;
    logic [1:0]   s;
    logic         ns;
    int           i;
    seed = 32'd81033;
    {reset, read, write, in_valid, in_no_snoop, in_instr, in_priv} = 7'h40;
    {address, writedata, in_kind, in_stream, in_addr, in_req_perm, rsp} = '0;
    {n_mismatch, checks_done, n_fault, cyc} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped place, then stream setup: 0 bypass, 1 split, 2 split with overrides
    reg_rd(REG_CTRL, 32'h0, 32'hffff_ffff);
    reg_acc(1'b1, 8'h40, 32'hffff_ffff, d);
    reg_rd(8'h40, 32'h0, 32'hffff_ffff);
    reg_acc(1'b1, REG_CTRL, 32'h7, d);
    reg_acc(1'b1, REG_STREAM_BASE, 32'h1, d);
    reg_acc(1'b1, REG_STREAM_BASE + 8'h4, 32'h1e, d);
    reg_acc(1'b1, REG_STREAM_BASE + 8'h8, 32'h2fe, d);
    reg_rd(REG_STREAM_BASE + 8'h8, 32'h2fe, 32'h3ff);
    reg_rd(REG_STREAM_BASE + 8'hc, 32'h0, 32'h3ff);
    $display("registers done");
    for (i = 0; i < 14; i++) begin
      a = {rnd(), rnd()} & PA_MASK;
      e = tab[(i + 2) % 3];
      a[59:56] = e;
      ns = i[0];
      r = 155'({rnd(), rnd(), rnd(), rnd(), rnd()});
      r[0] = 1'b0;
      r[90:27] = r[90:27] & PA_MASK;
      if (i < 6) begin
        oq.push_back('{{8'h0, a[55:0]}, nsd(e, ns), ns, ~ns});
        send(KIND_TRANS, 2'h0, a, ns, 3'h1, '0, ns, ~ns);
      end else begin
        s = i[1] ? 2'h2 : 2'h1;
        t = tab[i % 3];
        r[22:19] = t;
        m = mix(e, t);
        if (s == 2'h2) m[3:2] = t[3:2];
        oq.push_back('{r[90:27], nsd(m, ns), (s == 2'h2) | i[2], (s != 2'h2) & ~i[2]});
        send(KIND_TRANS, s, a, ns, 3'h1, r, i[2], ~i[2]);
      end
    end
    $display("translated done");
    for (i = 0; i < 4; i++) begin
      a = {rnd(), rnd()} & PA_MASK;
      r = 155'({rnd(), rnd(), rnd(), rnd(), rnd()});
      r[0] = 1'b0;
      p = 3'(rnd()) | 3'h1;
      cq.push_back('{{4'h0, mix(mix(ATTR_FIXED_IN, r[26:23]), r[22:19]), r[146:91]},
                     r[18:16] & r[15:13] & p, (r[12:7] < r[6:1]) ? r[12:7] : r[6:1]});
      send(KIND_TREQ, 2'h1, a, 1'b1, p, r, 1'b0, 1'b0);
    end
    $display("completions done");
    // Unconfigured stream and a failed walk are both dropped with a fault
    send(KIND_TRANS, 2'h3, a, 1'b0, 3'h1, '0, 1'b0, 1'b0);
    r[0] = 1'b1;
    send(KIND_TRANS, 2'h1, a, 1'b0, 3'h1, r, 1'b0, 1'b0);
    // Without attribute encoding the fixed input attribute is used
    reg_acc(1'b1, REG_CTRL, 32'h5, d);
    r[0] = 1'b0;
    r[22:19] = 4'ha;
    oq.push_back('{{8'h0, a[55:0]}, ATTR_FIXED_IN, 1'b0, 1'b0});
    send(KIND_TRANS, 2'h0, a, 1'b0, 3'h1, '0, 1'b0, 1'b0);
    oq.push_back('{r[90:27], 4'hb, 1'b0, 1'b0});
    send(KIND_TRANS, 2'h1, a, 1'b0, 3'h1, r, 1'b0, 1'b0);
    // Check off: a mode 10 stream bypasses; untranslated traffic merges both stages
    reg_acc(1'b1, REG_CTRL, 32'h4, d);
    oq.push_back('{{8'h0, a[55:0]}, ATTR_NOSNOOP, 1'b0, 1'b1});
    send(KIND_TRANS, 2'h1, a, 1'b1, 3'h1, r, 1'b0, 1'b1);
    oq.push_back('{r[90:27], nsd(mix(mix(ATTR_FIXED_IN, r[26:23]), r[22:19]), 1'b1), 1'b1, 1'b0});
    send(KIND_UNTRANS, 2'h1, a, 1'b1, 3'h1, r, 1'b1, 1'b0);
    for (i = 0; i < 100 && (oq.size() != 0 || cq.size() != 0); i++) @(posedge clk);
    if (i == 100) give_up("results");
    repeat (3) @(posedge clk);
    chk("fault_count", 64'd2, 64'(n_fault));
    reg_rd(REG_FAULTS, 32'h2, 32'hffff);
    $display("faults done");
    test_done();
  end
endmodule

// file: verif/walk_model.sv
// Table-walker stand-in: answers each walk after one or four cycles in turn
module walk_model (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Walk request and the answer the bench prepared
  input  wire logic         walk_valid,
  input  wire logic [154:0] rsp,
  // Walk answer
  output logic              walk_done,
  output logic [154:0]      rsp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  logic       slow;

  // Alternate prompt and slow answers; done is a one-cycle pulse
  always @(posedge clk) begin
    if (reset) begin
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      walk_done <= 1'b0;
    end else if (walk_done) begin
      walk_done <= 1'b0;
    end else if (walk_valid && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      walk_done <= 1'b1;
      wait_cnt <= 2'h0;
      slow <= ~slow;
    end else if (walk_valid) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // Outside the done cycle the data are inverted so stale values never pass
  assign rsp_out = walk_done ? rsp : ~rsp;
endmodule
